// File: src/i2crd_pkg.sv
package i2crd_pkg;
  // target address and direction
  localparam logic [6:0] ADDR_DEFAULT  = 7'h68;
  localparam logic       DIR_WRITE     = 1'b0;
  localparam logic       DIR_READ      = 1'b1;
  // command byte 0
  localparam int         OPC_LSB       = 0;
  localparam int         OPC_MSB       = 2;
  localparam logic [2:0] OPC_READ      = 3'h4;
  // command byte 1 / 2 fields
  localparam int         PSEL_HI_LSB   = 0;
  localparam int         PSEL_HI_MSB   = 3;
  localparam int         PSEL_LO_BIT   = 7;
  localparam int         BE_LSB        = 2;
  localparam int         BE_MSB        = 5;
  localparam int         AHI_LSB       = 0;
  localparam int         AHI_MSB       = 1;
  // widths
  localparam int         PSEL_W        = 5;
  localparam int         BE_W          = 4;
  localparam int         RADDR_W       = 12;
  localparam int         CMD_BYTES     = 4;
  localparam int         DATA_BYTES    = 4;
  // reset values
  localparam logic [7:0] BYTE_RST      = 8'h00;
  localparam logic [2:0] CNT_RST       = 3'h0;
endpackage : i2crd_pkg

// File: src/i2crd_sync.sv
`timescale 1ns/1ps
`default_nettype none
module i2crd_sync
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // pin level in, synchronised level out
  input  wire logic din,
  output var  logic dout
);
  logic meta_reg;

  // two stages; first stage feeds only the second
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta_reg <= 1'b1;
      dout     <= 1'b1;
    end
    else
    begin
      meta_reg <= din;
      dout     <= meta_reg;
    end
  end
endmodule : i2crd_sync
`default_nettype wire

// File: src/i2crd_target.sv
// Summary of operation
// - write packet: address then direction zero
// - command byte0 bits2:0 = 100 read
// - byte2 bits5:2 hold byte enables
// - address 11:10 in byte2, 9:2 byte3
// - read packet: same address, direction one
// - return four bytes, MSB first
// - five-bit port select across bytes 1,2
// - past four bytes, wrap to MSB
// - repeated start accepted like stop+start
// - register address bits 1:0 forced zero
`timescale 1ns/1ps
`default_nettype none
module i2crd_target
  import i2crd_pkg::*;
(
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst,
  // two-wire pins (oe low = drive low)
  input  wire logic                      scl_in,
  input  wire logic                      sda_in,
  output logic                           sda_out,
  output logic                           sda_oe_n,
  // target address strap
  input  wire logic [6:0]                dev_addr,
  // register fetch to the core
  output logic                           rd_req,
  output logic [i2crd_pkg::PSEL_W-1:0]   rd_port,
  output logic [i2crd_pkg::BE_W-1:0]     rd_be,
  output logic [i2crd_pkg::RADDR_W-1:0]  rd_addr,
  input  wire logic [31:0]               rd_data,
  // status
  output logic                           cmd_bad
);
  import i2crd_pkg::*;

  typedef enum logic [4:0] {
    I2CRD_IDLE = 5'h01,
    I2CRD_ADDR = 5'h02,
    I2CRD_CMD  = 5'h04,
    I2CRD_DATA = 5'h08,
    I2CRD_WAIT = 5'h10
  } i2crd_state_t;

  i2crd_state_t st_reg;
  logic         scl_s, sda_s, scl_d_reg, sda_d_reg;
  logic         scl_rise, scl_fall, start_ev, stop_ev;
  logic [7:0]   sh_reg;
  logic [3:0]   bit_reg;
  logic [2:0]   idx_reg;
  logic         ack_reg, tx_reg, rd_dir_reg, data_ok_reg, armed_reg;
  logic [7:0]   cb0_reg, cb1_reg, cb2_reg;
  logic [31:0]  buf_reg;
  logic [1:0]   bsel_reg;

  i2crd_sync u_scl (.clk(clk), .rst(rst), .din(scl_in), .dout(scl_s));
  i2crd_sync u_sda (.clk(clk), .rst(rst), .din(sda_in), .dout(sda_s));

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end
    else
    begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end

  assign scl_rise = scl_s & ~scl_d_reg;
  assign scl_fall = ~scl_s & scl_d_reg;
  assign start_ev = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  assign stop_ev  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

  // the scl fall that closes a start is no bit; without this the first byte loses a bit
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      armed_reg <= 1'b0;
    else if (start_ev)
      armed_reg <= 1'b0;
    else if (scl_rise)
      armed_reg <= 1'b1;
  end

  // byte engine; bits 0..7 data, 8 = ack slot
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_reg      <= I2CRD_IDLE;
      sh_reg      <= BYTE_RST;
      bit_reg     <= 4'h0;
      idx_reg     <= CNT_RST;
      ack_reg     <= 1'b0;
      tx_reg      <= 1'b0;
      rd_dir_reg  <= 1'b0;
      cb0_reg     <= BYTE_RST;
      cb1_reg     <= BYTE_RST;
      cb2_reg     <= BYTE_RST;
      rd_addr     <= '0;
      rd_req      <= 1'b0;
      data_ok_reg <= 1'b0;
      cmd_bad     <= 1'b0;
      bsel_reg    <= 2'h0;
      buf_reg     <= 32'h0000_0000;
    end
    else
    begin
      rd_req <= 1'b0;
      if (rd_req)
        buf_reg <= rd_data;
      if (start_ev)
      begin
        st_reg  <= I2CRD_ADDR;
        bit_reg <= 4'h0;
        ack_reg <= 1'b0;
        tx_reg  <= 1'b0;
      end
      else if (stop_ev)
      begin
        st_reg  <= I2CRD_IDLE;
        ack_reg <= 1'b0;
        tx_reg  <= 1'b0;
      end
      else if (scl_rise && bit_reg < 4'h8 && !tx_reg)
      begin
        sh_reg  <= {sh_reg[6:0], sda_s};
      end
      else if (scl_rise && bit_reg == 4'h8 && tx_reg && sda_s)
      begin
        st_reg <= I2CRD_WAIT;
      end
      else if (scl_fall && armed_reg && st_reg != I2CRD_IDLE && st_reg != I2CRD_WAIT)
      begin
        if (bit_reg == 4'h7 && !tx_reg)
        begin
          bit_reg <= 4'h8;
          case (st_reg)
            I2CRD_ADDR:
            begin
              if (sh_reg[7:1] == dev_addr)
              begin
                ack_reg    <= 1'b1;
                rd_dir_reg <= sh_reg[0];
                idx_reg    <= CNT_RST;
              end
              else
                st_reg <= I2CRD_WAIT;
            end
            I2CRD_CMD:
            begin
              ack_reg <= 1'b1;
              case (idx_reg)
                3'h0: cb0_reg <= sh_reg;
                3'h1: cb1_reg <= sh_reg;
                3'h2: cb2_reg <= sh_reg;
                default:
                begin
                  rd_addr <= {cb2_reg[AHI_MSB:AHI_LSB], sh_reg, 2'b00};
                  cmd_bad <= cb0_reg[OPC_MSB:OPC_LSB] != OPC_READ;
                  rd_req  <= cb0_reg[OPC_MSB:OPC_LSB] == OPC_READ;
                  data_ok_reg <= cb0_reg[OPC_MSB:OPC_LSB] == OPC_READ;
                end
              endcase
              idx_reg <= idx_reg + 3'h1;
            end
            default: ;
          endcase
        end
        else if (bit_reg == 4'h7 && tx_reg)
        begin
          bit_reg <= 4'h8;
          tx_reg  <= 1'b1;
        end
        else if (bit_reg == 4'h8)
        begin
          bit_reg <= 4'h0;
          ack_reg <= 1'b0;
          if (st_reg == I2CRD_ADDR)
          begin
            st_reg   <= rd_dir_reg ? I2CRD_DATA : I2CRD_CMD;
            tx_reg   <= rd_dir_reg;
            bsel_reg <= 2'h3;
          end
          else if (st_reg == I2CRD_DATA)
            bsel_reg <= bsel_reg - 2'h1;
        end
        else
          bit_reg <= bit_reg + 4'h1;
      end
    end
  end

  // bytes 3..0 of the buffer, wrap via 2-bit select
  logic [7:0] tx_byte;
  always_comb
  begin
    case (bsel_reg)
      2'h3:    tx_byte = buf_reg[31:24];
      2'h2:    tx_byte = buf_reg[23:16];
      2'h1:    tx_byte = buf_reg[15:8];
      default: tx_byte = buf_reg[7:0];
    endcase
  end

  // pin drive: only low is ever driven
  always_comb
  begin
    sda_out  = 1'b0;
    sda_oe_n = 1'b1;
    if (ack_reg && bit_reg == 4'h8)
      sda_oe_n = 1'b0;
    else if (tx_reg && st_reg == I2CRD_DATA && bit_reg < 4'h8)
      sda_oe_n = tx_byte[3'h7 - bit_reg[2:0]] | ~data_ok_reg;
  end

  assign rd_port = {cb1_reg[PSEL_HI_MSB:PSEL_HI_LSB], cb2_reg[PSEL_LO_BIT]};
  assign rd_be   = cb2_reg[BE_MSB:BE_LSB];

  a_cmd_req_opc : assert property (@(posedge clk) disable iff (rst)
    rd_req |-> $past(cb0_reg[2:0]) == 3'h4 && rd_addr[1:0] == 2'b00)
    else $error("fetch without read opcode");
  a_wrap_msb : assert property (@(posedge clk) disable iff (rst)
    st_reg == I2CRD_DATA && bsel_reg == 2'h0 && scl_fall && bit_reg == 4'h8
    |=> bsel_reg == 2'h3)
    else $error("no wrap to msb");
  a_ack_on_match : assert property (@(posedge clk) disable iff (rst)
    scl_fall && armed_reg && st_reg == I2CRD_ADDR && bit_reg == 4'h7 && !tx_reg && sh_reg[7:1] == dev_addr
    |=> !sda_oe_n)
    else $error("ack not driven");
  a_req_pulse : assert property (@(posedge clk) disable iff (rst)
    rd_req |=> !rd_req && buf_reg == $past(rd_data))
    else $error("buffer not loaded");
  a_msb_first : assert property (@(posedge clk) disable iff (rst)
    st_reg == I2CRD_DATA && tx_reg && bit_reg == 4'h0 && bsel_reg == 2'h3 && data_ok_reg
    |-> sda_oe_n == buf_reg[31])
    else $error("first bit not byte 3 msb");
  a_nak_ends_tx : assert property (@(posedge clk) disable iff (rst)
    st_reg == I2CRD_DATA && scl_rise && bit_reg == 4'h8 && tx_reg && sda_s
    |=> st_reg == I2CRD_WAIT && sda_oe_n)
    else $error("nak did not end transmit");
  c_read_seen : cover property (@(posedge clk) rd_req);
  c_wrap_seen : cover property (@(posedge clk) st_reg == I2CRD_DATA && bsel_reg == 2'h0);
  c_rstart    : cover property (@(posedge clk) start_ev && st_reg == I2CRD_CMD);
endmodule : i2crd_target
`default_nettype wire

// File: verif/i2crd_master.sv
`timescale 1ns/1ps
`default_nettype none
module i2crd_master
(
  // clock
  input  wire logic clk,
  // bus lines
  output logic      scl,
  output logic      sda_m,
  input  wire logic sda_oe_n,
  input  wire logic sda_out,
  output logic      sda
);
  // pull-up: released wire reads high
  assign sda = sda_m & (sda_oe_n | sda_out);
  initial
  begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  task automatic tick();
    repeat (2) @(posedge clk);
  endtask : tick
  // extra wait lets the target drop its ack first
  task automatic start();
    tick();
    tick();
    sda_m <= 1'b1;
    tick();
    scl <= 1'b1;
    tick();
    sda_m <= 1'b0;
    tick();
    scl <= 1'b0;
  endtask : start
  task automatic stop();
    tick();
    tick();
    sda_m <= 1'b0;
    tick();
    scl <= 1'b1;
    tick();
    sda_m <= 1'b1;
    tick();
  endtask : stop
  task automatic bit_io(input logic b, output logic r);
    tick();
    sda_m <= b;
    tick();
    scl <= 1'b1;
    tick();
    r = sda;
    tick();
    scl <= 1'b0;
  endtask : bit_io
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask : wbyte
  task automatic rbyte(input logic nak, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(nak, r);
  endtask : rbyte
endmodule : i2crd_master
`default_nettype wire

// File: verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fail_count++; \
  $display("unexpected at %0t: got %h expected %h", $time, (a), (b)); end end
module testbench;
  import i2crd_pkg::*;
  logic              clk, rst, scl, sda_m, sda, sda_oe_n, sda_out, rd_req, cmd_bad, ack;
  logic [PSEL_W-1:0] rd_port, cap_port;
  logic [BE_W-1:0]   rd_be, cap_be;
  logic [11:0]       rd_addr, cap_addr;
  logic [31:0]       rd_data;
  logic [7:0]        d;
  int                fail_count = 0, n_checks = 0, n_req = 0, cyc = 0;
  // core answer tied to the address, so a stale fetch shows
  assign rd_data = {rd_addr, 8'hA5, ~rd_addr};
  i2crd_target dut_u (.clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .dev_addr(ADDR_DEFAULT), .rd_req(rd_req), .rd_port(rd_port), .rd_be(rd_be), .rd_addr(rd_addr),
    .rd_data(rd_data), .cmd_bad(cmd_bad));
  i2crd_master m_u (.clk(clk), .scl(scl), .sda_m(sda_m), .sda_oe_n(sda_oe_n), .sda_out(sda_out), .sda(sda));
  task automatic print_verdict();
    if (fail_count == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (rd_req === 1'b1)
    begin
      n_req <= n_req + 1;
      cap_port <= rd_port;
      cap_be <= rd_be;
      cap_addr <= rd_addr;
    end
    if (cyc == 30000)
    begin
      fail_count++;
      print_verdict();
    end
  end
  task automatic rd_xfer(input logic [31:0] cmd, input logic rs, input logic [4:0] ep,
                         input logic [3:0] eb, input logic [11:0] ea);
    int q;
    q = n_req;
    m_u.start();
    m_u.wbyte({ADDR_DEFAULT, DIR_WRITE}, ack);
    `CHK(ack, 1'b1)
    for (int i = 3; i >= 0; i--)
    begin
      m_u.wbyte(cmd[8*i +: 8], ack);
      `CHK(ack, 1'b1)
    end
    if (!rs) m_u.stop();
    m_u.start();
    `CHK(n_req, q + 1)
    `CHK({cap_port, cap_be, cap_addr, cmd_bad}, {ep, eb, ea, 1'b0})
    m_u.wbyte({ADDR_DEFAULT, DIR_READ}, ack);
    `CHK(ack, 1'b1)
    for (int i = 0; i < 5; i++)
    begin
      m_u.rbyte(i == 4, d);
      `CHK(d, ({ea, 8'hA5, ~ea} >> (8 * (3 - i % 4))) & 32'hFF)
    end
    m_u.stop();
  endtask : rd_xfer
  task automatic t_refused();
    int q;
    q = n_req;
    m_u.start();
    m_u.wbyte({ADDR_DEFAULT ^ 7'h01, DIR_WRITE}, ack);
    `CHK(ack, 1'b0)
    m_u.stop();
    m_u.start();
    m_u.wbyte({ADDR_DEFAULT, DIR_WRITE}, ack);
    for (int i = 0; i < 4; i++) m_u.wbyte(i == 0 ? 8'h05 : 8'h00, ack);
    m_u.stop();
    `CHK({cmd_bad, n_req == q}, 2'b11)
    m_u.start();
    m_u.wbyte({ADDR_DEFAULT, DIR_READ}, ack);
    m_u.rbyte(1'b1, d);
    `CHK(d, 8'hFF)
    m_u.stop();
  endtask : t_refused
  task automatic t_two_packets();
    rd_xfer(32'h04003C3E, 1'b0, 5'd0, 4'hF, 12'h0F8);
  endtask : t_two_packets
  task automatic t_rep_start();
    // low select bit, sparse enables, top address bits
    rd_xfer(32'h04009681, 1'b1, 5'd1, 4'h5, 12'hA04);
    rd_xfer(32'h04013C00, 1'b1, 5'd2, 4'hF, 12'h000);
  endtask : t_rep_start
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    rst = 1'b1;
    repeat (16) @(posedge clk);
    `CHK({sda_oe_n, sda_out, rd_req, cmd_bad}, 4'b1000)
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    t_refused();
    t_two_packets();
    t_rep_start();
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
